// ### logic/ads_pkg.sv
// shared constants and types of the sampling sequencer
package ads_pkg;

  // ****************************************
  // widths and clock
  // ****************************************
  localparam int unsigned CLK_NS   = 100;
  localparam int unsigned RES_W    = 12;
  localparam int unsigned TMR_W    = 22;
  localparam int unsigned SPI_BITS = 24;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] REG_CMD      = 8'h00;
  localparam logic [7:0] REG_CFG      = 8'h04;
  localparam logic [7:0] REG_XADDR    = 8'h08;
  localparam logic [7:0] REG_INTERVAL = 8'h0C;
  localparam logic [7:0] REG_COUNT    = 8'h10;
  localparam logic [7:0] REG_RESULT   = 8'h14;
  localparam logic [7:0] REG_STATUS   = 8'h18;
  localparam logic [7:0] REG_PORT     = 8'h1C;

  localparam int unsigned CMD_SINGLE = 0;
  localparam int unsigned CMD_WIDE   = 1;
  localparam int unsigned CMD_NARROW = 2;
  localparam int unsigned CMD_ON     = 3;
  localparam int unsigned CMD_OFF    = 4;
  localparam int unsigned CMD_INIT   = 5;
  localparam int unsigned CMD_SAFE   = 6;

  localparam int unsigned CFG_FLAG_LSB = 0;
  localparam int unsigned CFG_CHAN_LSB = 4;

  localparam int unsigned STAT_BUSY    = 0;
  localparam int unsigned STAT_DONE    = 1;
  localparam int unsigned STAT_REFUSED = 2;
  localparam int unsigned STAT_CONV_ON = 3;
  localparam int unsigned STAT_INIT    = 4;

  // ****************************************
  // conversion flags and coding
  // ****************************************
  localparam logic [2:0]  FLAG_SE_UNI   = 3'h7;
  localparam logic [2:0]  FLAG_DIFF_UNI = 3'h0;
  localparam logic [2:0]  FLAG_SE_BIP   = 3'h1;
  localparam logic [2:0]  FLAG_DIFF_BIP = 3'h2;
  localparam logic [15:0] COMMON_BASE   = 16'h8000;
  localparam logic [11:0] MID_SCALE     = 12'h800;

  localparam int unsigned FRM_START = 23;
  localparam int unsigned FRM_CHAN  = 20;
  localparam int unsigned FRM_BIP   = 19;
  localparam int unsigned FRM_SGL   = 18;
  localparam int unsigned FRM_RES   = 3;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned STEP_NS       = 2500;
  localparam int unsigned W_PER_COM_NS  = 27500;
  localparam int unsigned W_PER_PAG_NS  = 50000;
  localparam int unsigned N_PER_COM_NS  = 10000;
  localparam int unsigned N_PER_PAG_NS  = 32500;
  localparam int unsigned W_LAT_COM_NS  = 58000;
  localparam int unsigned W_LAT_PAG_NS  = 68000;
  localparam int unsigned W_SLAT_COM_NS = 128000;
  localparam int unsigned W_SLAT_PAG_NS = 138000;
  localparam int unsigned N_LAT_COM_NS  = 16000;
  localparam int unsigned N_LAT_PAG_NS  = 11000;
  localparam int unsigned N_SLAT_COM_NS = 86000;
  localparam int unsigned N_SLAT_PAG_NS = 81000;

  localparam logic [TMR_W-1:0] STEP_CYC       = TMR_W'(STEP_NS / CLK_NS);
  localparam logic [TMR_W-1:0] W_PER_COM_CYC  = TMR_W'(W_PER_COM_NS / CLK_NS);
  localparam logic [TMR_W-1:0] W_PER_PAG_CYC  = TMR_W'(W_PER_PAG_NS / CLK_NS);
  localparam logic [TMR_W-1:0] N_PER_COM_CYC  = TMR_W'(N_PER_COM_NS / CLK_NS);
  localparam logic [TMR_W-1:0] N_PER_PAG_CYC  = TMR_W'(N_PER_PAG_NS / CLK_NS);
  localparam logic [TMR_W-1:0] W_LAT_COM_CYC  = TMR_W'(W_LAT_COM_NS / CLK_NS);
  localparam logic [TMR_W-1:0] W_LAT_PAG_CYC  = TMR_W'(W_LAT_PAG_NS / CLK_NS);
  localparam logic [TMR_W-1:0] W_SLAT_COM_CYC = TMR_W'(W_SLAT_COM_NS / CLK_NS);
  localparam logic [TMR_W-1:0] W_SLAT_PAG_CYC = TMR_W'(W_SLAT_PAG_NS / CLK_NS);
  localparam logic [TMR_W-1:0] N_LAT_COM_CYC  = TMR_W'(N_LAT_COM_NS / CLK_NS);
  localparam logic [TMR_W-1:0] N_LAT_PAG_CYC  = TMR_W'(N_LAT_PAG_NS / CLK_NS);
  localparam logic [TMR_W-1:0] N_SLAT_COM_CYC = TMR_W'(N_SLAT_COM_NS / CLK_NS);
  localparam logic [TMR_W-1:0] N_SLAT_PAG_CYC = TMR_W'(N_SLAT_PAG_NS / CLK_NS);
  localparam logic [TMR_W-1:0] ONE_CYC        = 22'h000001;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_LAT  = 4'h2,
    ST_CONV = 4'h4,
    ST_GAP  = 4'h8
  } ads_state_type;

endpackage

// ### logic/ads_sampling_sequencer.sv
// sampling sequencer for a serial 12-bit converter and the internal 8-bit one
// Overview of operation
// - serial converter reached over spi with select
// - eight single-ended, four differential, or mixed
// - request carries flag and channel number
// - single request: one conversion, result returned
// - unipolar coding 0 to 4095, mid 2048
// - internal converter off after reset, pins digital
// - enable makes pins analog, disable digital
// - multi run stores consecutive results from start
// - spacing is base plus 2.5 us per count
// - wide base 27.5 us common, 50 us paged
// - narrow base 10 us common, 32.5 us paged
// - wide first sample after 58/68 or 128/138 us
// - narrow first sample after 16/11 or 86/81 us
// - bipolar flags give signed serial reading; narrow runs store raw 8-bit data
`timescale 1ns/1ps
module ads_sampling_sequencer #(
  parameter int SCLK_HALF = 4
) (
  input  logic        clk,
  input  logic        reset,
  input  logic [7:0]  addr,
  input  logic [31:0] wdata,
  input  logic        wr,
  input  logic        rd,
  output logic [31:0] rdata,
  output logic        spi_sclk,
  output logic        spi_mosi,
  input  logic        spi_miso,
  output logic        serial_cs_n,
  output logic        mem_wr,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input  logic [7:0]  shared_analog_input_port,
  output logic        analog_mode,
  output logic [2:0]  narrow_conv_channel,
  input  logic [7:0]  narrow_conv_data
);

  localparam int TW = ads_pkg::TMR_W;
  localparam int SB = ads_pkg::SPI_BITS;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    ads_pkg::ads_state_type st;
    logic                   conv_on;
    logic                   init_done;
    logic [2:0]             flag;
    logic [2:0]             chan;
    logic [15:0]            xaddr;
    logic [15:0]            interval;
    logic [15:0]            count;
    logic                   run_wide;
    logic                   run_multi;
    logic                   run_common;
    logic                   run_safe;
    logic [2:0]             run_flag;
    logic [2:0]             run_chan;
    logic [TW-1:0]          run_per;
    logic [15:0]            ptr;
    logic [15:0]            left;
    logic [15:0]            result;
    logic                   done;
    logic                   refused;
    logic [31:0]            rdata;
    logic                   mem_wr;
    logic [15:0]            mem_addr;
    logic [15:0]            mem_wdata;
    logic [TW-1:0]          ev_cnt;
  } ads_seq_type;

  localparam ads_seq_type RST = '{st: ads_pkg::ST_IDLE, default: '0};

  ads_seq_type   r;
  ads_seq_type   n;
  logic [7:0]    cmd;
  logic          req;
  logic          req_single;
  logic          req_wide;
  logic          req_narrow;
  logic          req_common;
  logic          bad;
  logic          sample;
  logic          tmr_load;
  logic [TW-1:0] tmr_value;
  logic          tmr_expire;
  logic          spi_start;
  logic [SB-1:0] spi_tx;
  logic [SB-1:0] spi_rx;
  logic          spi_done;
  logic [11:0]   raw;
  logic          bip;
  logic [15:0]   coded;

  if (SCLK_HALF < 1 ||
      SB * 2 * SCLK_HALF + 4 >= int'(ads_pkg::W_PER_COM_CYC)) begin : g_chk
    $error("spi clock too slow for the fastest sample period");
  end

  // ****************************************
  // timing tables
  // ****************************************
  function automatic logic [TW-1:0] lat_of(input logic wide, input logic common,
                                           input logic safe);
    logic [TW-1:0] v;
    v = '0;
    unique case ({wide, common, safe})
      3'h0:    v = ads_pkg::N_LAT_PAG_CYC;
      3'h1:    v = ads_pkg::N_SLAT_PAG_CYC;
      3'h2:    v = ads_pkg::N_LAT_COM_CYC;
      3'h3:    v = ads_pkg::N_SLAT_COM_CYC;
      3'h4:    v = ads_pkg::W_LAT_PAG_CYC;
      3'h5:    v = ads_pkg::W_SLAT_PAG_CYC;
      3'h6:    v = ads_pkg::W_LAT_COM_CYC;
      default: v = ads_pkg::W_SLAT_COM_CYC;
    endcase
    return v;
  endfunction

  function automatic logic [TW-1:0] per_of(input logic wide, input logic common,
                                           input logic [15:0] ivl);
    logic [TW-1:0] base;
    base = wide ? (common ? ads_pkg::W_PER_COM_CYC : ads_pkg::W_PER_PAG_CYC)
                : (common ? ads_pkg::N_PER_COM_CYC : ads_pkg::N_PER_PAG_CYC);
    return TW'(base + TW'(ivl) * ads_pkg::STEP_CYC);
  endfunction

  // ****************************************
  // helpers
  // ****************************************
  ads_timer #(.W(TW)) u_timer (
    .clk    (clk),
    .reset  (reset),
    .load   (tmr_load),
    .value  (tmr_value),
    .expire (tmr_expire)
  );

  ads_spi #(.BITS(SB), .HALF(SCLK_HALF)) u_spi (
    .clk   (clk),
    .reset (reset),
    .start (spi_start),
    .tx    (spi_tx),
    .miso  (spi_miso),
    .done  (spi_done),
    .rx    (spi_rx),
    .sclk  (spi_sclk),
    .mosi  (spi_mosi),
    .cs_n  (serial_cs_n)
  );

  always_comb begin
    bip    = (r.run_flag == ads_pkg::FLAG_SE_BIP) ||
             (r.run_flag == ads_pkg::FLAG_DIFF_BIP);
    spi_tx = '0;
    spi_tx[ads_pkg::FRM_START] = 1'b1;
    spi_tx[ads_pkg::FRM_CHAN +: 3] = r.run_chan;
    spi_tx[ads_pkg::FRM_BIP] = bip;
    spi_tx[ads_pkg::FRM_SGL] = (r.run_flag == ads_pkg::FLAG_SE_UNI) ||
                               (r.run_flag == ads_pkg::FLAG_SE_BIP);
    raw    = spi_rx[ads_pkg::FRM_RES +: ads_pkg::RES_W];
    if (bip) begin
      coded = {{4{~raw[11]}}, ~raw[11], raw[10:0]};
    end else begin
      coded = {4'h0, raw};
    end
  end

  // ****************************************
  // register access and sequencing
  // ****************************************
  always_comb begin
    n          = r;
    n.mem_wr   = 1'b0;
    n.rdata    = '0;
    n.ev_cnt   = r.ev_cnt + 1'b1;
    sample     = 1'b0;
    tmr_load   = 1'b0;
    tmr_value  = ads_pkg::ONE_CYC;
    spi_start  = 1'b0;
    cmd        = (wr && addr == ads_pkg::REG_CMD) ? wdata[7:0] : 8'h00;
    req        = cmd[ads_pkg::CMD_SINGLE] | cmd[ads_pkg::CMD_WIDE] |
                 cmd[ads_pkg::CMD_NARROW];
    req_single = cmd[ads_pkg::CMD_SINGLE];
    req_wide   = !req_single && cmd[ads_pkg::CMD_WIDE];
    req_narrow = !req_single && !req_wide && cmd[ads_pkg::CMD_NARROW];
    req_common = (r.xaddr >= ads_pkg::COMMON_BASE);
    bad        = req_narrow ? !r.conv_on
                            : (!r.init_done || (r.flag > ads_pkg::FLAG_DIFF_BIP &&
                                                r.flag != ads_pkg::FLAG_SE_UNI));
    if (wr) begin
      unique case (addr)
        ads_pkg::REG_CFG: begin
          n.flag = wdata[ads_pkg::CFG_FLAG_LSB +: 3];
          n.chan = wdata[ads_pkg::CFG_CHAN_LSB +: 3];
        end
        ads_pkg::REG_XADDR:    n.xaddr    = wdata[15:0];
        ads_pkg::REG_INTERVAL: n.interval = wdata[15:0];
        ads_pkg::REG_COUNT:    n.count    = wdata[15:0];
        ads_pkg::REG_STATUS: begin
          if (wdata[ads_pkg::STAT_DONE]) begin
            n.done = 1'b0;
          end
          if (wdata[ads_pkg::STAT_REFUSED]) begin
            n.refused = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (cmd[ads_pkg::CMD_ON]) begin
      n.conv_on = 1'b1;
    end
    if (cmd[ads_pkg::CMD_OFF]) begin
      n.conv_on = 1'b0;
    end
    if (cmd[ads_pkg::CMD_INIT]) begin
      n.init_done = 1'b1;
    end
    unique case (r.st)
      ads_pkg::ST_IDLE: begin
        if (req && bad) begin
          n.refused = 1'b1;
        end else if (req) begin
          n.run_wide   = !req_narrow;
          n.run_multi  = !req_single;
          n.run_common = req_common;
          n.run_safe   = wdata[ads_pkg::CMD_SAFE];
          n.run_flag   = r.flag;
          n.run_chan   = r.chan;
          n.run_per    = per_of(!req_narrow, req_common, r.interval);
          n.ptr        = r.xaddr;
          n.left       = r.count;
          n.ev_cnt     = ads_pkg::ONE_CYC;
          if (!req_single && r.count == '0) begin
            n.done = 1'b1;
          end else begin
            tmr_load  = 1'b1;
            tmr_value = req_single ? ads_pkg::ONE_CYC
                                   : lat_of(!req_narrow, req_common,
                                            wdata[ads_pkg::CMD_SAFE]);
            n.st      = ads_pkg::ST_LAT;
          end
        end
      end
      ads_pkg::ST_LAT, ads_pkg::ST_GAP: begin
        if (tmr_expire) begin
          sample   = 1'b1;
          n.ev_cnt = ads_pkg::ONE_CYC;
          if (r.run_multi && (r.run_wide || r.left != 16'h0001)) begin
            tmr_load  = 1'b1;
            tmr_value = r.run_per;
          end
          if (r.run_wide) begin
            spi_start = 1'b1;
            n.st      = ads_pkg::ST_CONV;
          end else begin
            n.mem_wr    = 1'b1;
            n.mem_addr  = r.ptr;
            n.mem_wdata = {8'h00, narrow_conv_data};
            n.ptr       = r.ptr + 1'b1;
            n.left      = r.left - 1'b1;
            n.st        = (r.left == 16'h0001) ? ads_pkg::ST_IDLE : ads_pkg::ST_GAP;
            n.done      = n.done | (r.left == 16'h0001);
          end
        end
      end
      ads_pkg::ST_CONV: begin
        if (spi_done && r.run_multi) begin
          n.mem_wr    = 1'b1;
          n.mem_addr  = r.ptr;
          n.mem_wdata = coded;
          n.ptr       = r.ptr + 1'b1;
          n.left      = r.left - 1'b1;
          n.st        = (r.left == 16'h0001) ? ads_pkg::ST_IDLE : ads_pkg::ST_GAP;
          n.done      = n.done | (r.left == 16'h0001);
        end else if (spi_done) begin
          n.result = coded;
          n.st     = ads_pkg::ST_IDLE;
          n.done   = 1'b1;
        end
      end
    endcase
    if (req && r.st != ads_pkg::ST_IDLE) begin
      n.refused = 1'b1;
    end
    if (rd) begin
      unique case (addr)
        ads_pkg::REG_CFG: begin
          n.rdata[ads_pkg::CFG_FLAG_LSB +: 3] = r.flag;
          n.rdata[ads_pkg::CFG_CHAN_LSB +: 3] = r.chan;
        end
        ads_pkg::REG_XADDR:    n.rdata[15:0] = r.xaddr;
        ads_pkg::REG_INTERVAL: n.rdata[15:0] = r.interval;
        ads_pkg::REG_COUNT:    n.rdata[15:0] = r.count;
        ads_pkg::REG_RESULT:   n.rdata[15:0] = r.result;
        ads_pkg::REG_STATUS: begin
          n.rdata[ads_pkg::STAT_BUSY]    = (r.st != ads_pkg::ST_IDLE);
          n.rdata[ads_pkg::STAT_DONE]    = r.done;
          n.rdata[ads_pkg::STAT_REFUSED] = r.refused;
          n.rdata[ads_pkg::STAT_CONV_ON] = r.conv_on;
          n.rdata[ads_pkg::STAT_INIT]    = r.init_done;
        end
        ads_pkg::REG_PORT:
          n.rdata[7:0] = r.conv_on ? 8'h00 : shared_analog_input_port;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  assign rdata               = r.rdata;
  assign mem_wr              = r.mem_wr;
  assign mem_addr            = r.mem_addr;
  assign mem_wdata           = r.mem_wdata;
  assign analog_mode         = r.conv_on;
  assign narrow_conv_channel = r.run_chan;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  cs_only_conv_a: assert property (!serial_cs_n |-> r.st == ads_pkg::ST_CONV)
    else $error("converter select low outside a conversion");
  se_uni_frame_a: assert property (spi_start && r.run_flag == ads_pkg::FLAG_SE_UNI
    |-> spi_tx[ads_pkg::FRM_SGL] && !spi_tx[ads_pkg::FRM_BIP])
    else $error("single-ended unipolar frame wrong");
  diff_bip_frame_a: assert property (spi_start && r.run_flag == ads_pkg::FLAG_DIFF_BIP
    |-> !spi_tx[ads_pkg::FRM_SGL] && spi_tx[ads_pkg::FRM_BIP])
    else $error("differential bipolar frame wrong");
  single_once_a: assert property (spi_start && !r.run_multi
    |=> (!spi_start && !mem_wr)[*8])
    else $error("single request started more than one conversion");
  uni_code_a: assert property (spi_done && r.st == ads_pkg::ST_CONV && !bip
    |=> (r.run_multi ? mem_wdata : r.result) == {4'h0, $past(raw)})
    else $error("unipolar result coding wrong");
  bip_code_a: assert property (spi_done && r.st == ads_pkg::ST_CONV && bip
    |=> (r.run_multi ? mem_wdata : r.result) ==
        16'({4'h0, $past(raw)} - {4'h0, ads_pkg::MID_SCALE}))
    else $error("bipolar result coding wrong");
  reset_off_a: assert property (@(posedge clk) disable iff (1'b0)
    reset |=> !analog_mode)
    else $error("internal converter on after reset");
  port_read_a: assert property (rd && addr == ads_pkg::REG_PORT && !analog_mode
    |=> rdata[7:0] == $past(shared_analog_input_port))
    else $error("digital port read wrong");
  conv_on_a: assert property (cmd[ads_pkg::CMD_ON] && !cmd[ads_pkg::CMD_OFF]
    |=> analog_mode)
    else $error("enable did not take effect");
  start_ptr_a: assert property ($rose(r.st == ads_pkg::ST_LAT) && r.run_multi
    |-> r.ptr == $past(r.xaddr))
    else $error("run does not start at the given address");
  spacing_a: assert property (sample && r.st == ads_pkg::ST_GAP
    |-> r.ev_cnt == r.run_per)
    else $error("sample spacing wrong");
  latency_a: assert property (sample && r.st == ads_pkg::ST_LAT && r.run_multi
    |-> r.ev_cnt == lat_of(r.run_wide, r.run_common, r.run_safe))
    else $error("first sample latency wrong");

  single_c: cover property (spi_done && !r.run_multi);
  wide_run_c: cover property (r.st == ads_pkg::ST_GAP && r.run_wide ##1 spi_start);
  narrow_run_c: cover property (mem_wr ##[1:400] mem_wr);
  refused_c: cover property (req && bad);

endmodule

// ### logic/ads_spi.sv
// spi master for one framed transfer, mode 0, msb first
`timescale 1ns/1ps
module ads_spi #(
  parameter int BITS = 24,
  parameter int HALF = 4
) (
  input  logic            clk,
  input  logic            reset,
  input  logic            start,
  input  logic [BITS-1:0] tx,
  input  logic            miso,
  output logic            done,
  output logic [BITS-1:0] rx,
  output logic            sclk,
  output logic            mosi,
  output logic            cs_n
);

  localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
  localparam int BW = $clog2(BITS + 1);

  typedef struct packed {
    logic            busy;
    logic            done;
    logic            cs_n;
    logic            sclk;
    logic [CW-1:0]   div;
    logic [BW-1:0]   left;
    logic [BITS-1:0] tx;
    logic [BITS-1:0] rx;
  } ads_spi_type;

  localparam ads_spi_type RST = '{cs_n: 1'b1, default: '0};

  ads_spi_type r;
  ads_spi_type n;

  if (HALF < 1 || BITS < 2) begin : g_chk
    $error("spi parameters out of range");
  end

  always_comb begin
    n = r;
    n.done = 1'b0;
    if (!r.busy) begin
      if (start) begin
        n.busy = 1'b1;
        n.cs_n = 1'b0;
        n.sclk = 1'b0;
        n.tx   = tx;
        n.left = BW'(BITS);
        n.div  = CW'(HALF - 1);
      end
    end else if (r.div != '0) begin
      n.div = r.div - 1'b1;
    end else begin
      n.div = CW'(HALF - 1);
      if (!r.sclk) begin
        n.sclk = 1'b1;
        n.rx   = {r.rx[BITS-2:0], miso};
      end else begin
        n.sclk = 1'b0;
        n.tx   = {r.tx[BITS-2:0], 1'b0};
        n.left = r.left - 1'b1;
        if (r.left == BW'(1)) begin
          n.busy = 1'b0;
          n.cs_n = 1'b1;
          n.done = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  assign done = r.done;
  assign rx   = r.rx;
  assign sclk = r.sclk;
  assign mosi = r.tx[BITS-1];
  assign cs_n = r.cs_n;

endmodule

// ### logic/ads_timer.sv
// one-shot cycle timer: expire is high exactly value cycles after load
`timescale 1ns/1ps
module ads_timer #(
  parameter int W = 22
) (
  input  logic         clk,
  input  logic         reset,
  input  logic         load,
  input  logic [W-1:0] value,
  output logic         expire
);

  typedef struct packed {
    logic         run;
    logic [W-1:0] cnt;
  } ads_tmr_type;

  ads_tmr_type r;
  ads_tmr_type n;

  if (W < 2) begin : g_chk
    $error("timer width too small");
  end

  always_comb begin
    n = r;
    if (load) begin
      n.run = (value != '0);
      n.cnt = value;
    end else if (r.run) begin
      n.cnt = r.cnt - 1'b1;
      if (r.cnt == W'(1)) begin
        n.run = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign expire = r.run && (r.cnt == W'(1));

endmodule

// ### verif/adc_sampling_sequencer_tb.sv
// self-checking bench of the sampling sequencer
`timescale 1ns/1ps
module adc_sampling_sequencer_tb;
  logic        clk, reset, wr, rd, sclk, mosi, miso, cs_n, mem_wr, amode;
  logic [7:0]  addr, pins, ndata;
  logic [31:0] wdata, rdata, v;
  logic [15:0] maddr, mdata;
  logic [2:0]  nch;
  logic [11:0] cval;
  int          n_fail, n_checks;
  ads_sampling_sequencer i_dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso),
    .serial_cs_n(cs_n), .mem_wr(mem_wr), .mem_addr(maddr), .mem_wdata(mdata),
    .shared_analog_input_port(pins), .analog_mode(amode), .narrow_conv_channel(nch),
    .narrow_conv_data(ndata));
  ads_conv_model i_conv (.sclk(sclk), .cs_n(cs_n), .val(cval), .miso(miso));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ****************************************
  // bus and check tasks
  // ****************************************
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task single(input logic [2:0] f, input logic [11:0] raw, input logic [15:0] exp);
    int i;
    cval = raw;
    wreg(ads_pkg::REG_CFG, {25'h0, 3'h3, 1'b0, f});
    wreg(ads_pkg::REG_CMD, 32'h01);
    for (i = 0; i < 300; i++) begin
      rreg(ads_pkg::REG_STATUS);
      if (v[1] === 1'b1) break;
    end
    chk("done", v[1], 1'b1);
    wreg(ads_pkg::REG_STATUS, 32'h6);
    rreg(ads_pkg::REG_RESULT);
    chk("result", v, {16'h0, exp});
  endtask
  task multi(input logic [31:0] cmd, input logic [15:0] xa, input int lat, input int per);
    int n, k;
    wreg(ads_pkg::REG_XADDR, {16'h0, xa});
    wreg(ads_pkg::REG_INTERVAL, 32'h2);
    wreg(ads_pkg::REG_COUNT, 32'h3);
    wreg(ads_pkg::REG_CMD, cmd);
    for (k = 0; k < 3; k++) begin
      for (n = 1; n < 2000; n++) begin
        @(negedge clk);
        if (mem_wr === 1'b1) break;
      end
      if (k > 0 || lat > 0) chk("gap", n, (k > 0) ? per : lat);
      chk("maddr", maddr, xa + 16'(k));
      chk("mdata", mdata, cmd[2] ? {8'h00, ndata} : 16'h0800);
    end
  endtask
  task t_reset;
    chk("mode", amode, 1'b0);
    chk("cs", cs_n, 1'b1);
    rreg(ads_pkg::REG_PORT);
    chk("port", v, {24'h0, pins});
    rreg(8'h40);
    chk("unmapped", v, 32'h0);
    $display("test reset finished");
  endtask
  task t_onoff;
    wreg(ads_pkg::REG_CMD, 32'h08);
    @(negedge clk);
    chk("mode", amode, 1'b1);
    rreg(ads_pkg::REG_PORT);
    chk("port", v, 32'h0);
    wreg(ads_pkg::REG_CMD, 32'h10);
    rreg(ads_pkg::REG_PORT);
    chk("port", v, {24'h0, pins});
    chk("mode", amode, 1'b0);
    $display("test on off finished");
  endtask
  task t_single;
    wreg(ads_pkg::REG_STATUS, 32'h6);
    wreg(ads_pkg::REG_CMD, 32'h01);
    rreg(ads_pkg::REG_STATUS);
    chk("refused", v[2], 1'b1);
    wreg(ads_pkg::REG_CMD, 32'h20);
    single(3'h7, 12'hFFF, 16'h0FFF);
    single(3'h0, 12'h800, 16'h0800);
    single(3'h1, 12'h000, 16'hF800);
    single(3'h2, 12'hFFF, 16'h07FF);
    $display("test single finished");
  endtask
  task t_multi;
    cval = 12'h800;
    wreg(ads_pkg::REG_CFG, 32'h37);
    wreg(ads_pkg::REG_CMD, 32'h08);
    multi(32'h02, 16'h8000, 774, 325);
    multi(32'h04, 16'h0100, 111, 375);
    chk("nch", nch, 3'h3);
    multi(32'h44, 16'h0100, 811, 375);
    $display("test multi finished");
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #4000000;
    n_fail++;
    print_verdict;
  end
  initial begin
    reset = 1'b1;
    {addr, wdata, wr, rd} = '0;
    pins = 8'hA5;
    ndata = 8'h5A;
    cval = 12'h000;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    t_reset;
    t_onoff;
    t_single;
    t_multi;
    print_verdict;
  end
endmodule

// ### verif/ads_conv_model.sv
// behavioural serial 12-bit converter at the far end of the spi link
`timescale 1ns/1ps
module ads_conv_model (
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic [11:0] val,
  output logic             miso
);
  logic [23:0] sh;
  initial miso = 1'b0;
  always @(negedge cs_n) begin
    sh = {9'h000, val, 3'h0};
    miso = sh[23];
  end
  always @(negedge sclk) if (!cs_n) begin
    sh = sh << 1;
    miso = sh[23];
  end
  always @(posedge cs_n) miso = ~miso;
endmodule
